// >>> verilog/plm_regs.svh
// Constants of the eight-cell output macrocell array
`ifndef PLM_REGS_SVH
`define PLM_REGS_SVH

// Array geometry
`define PLM_CELLS        8
`define PLM_TERMS        8
`define PLM_DED_INPUTS   8
`define PLM_LINES        16

// Product term that doubles as output enable
`define PLM_OE_TERM      0

// Special cell positions (cell i sits on I/O pin 12 + i)
`define PLM_OUTER_LO     0
`define PLM_OUTER_HI     7
`define PLM_CENTRE_LO    3
`define PLM_CENTRE_HI    4

// Reset values
`define PLM_REG_RST      8'h00
`define PLM_PIN_RST      8'hFF
`define PLM_OE_RST       8'h00

// Synchroniser reset: pins idle high, so no false clock edge follows reset
`define PLM_SYNC_RST     18'h3FFFF
`define PLM_PCLK_RST     1'h1

`endif

// >>> verilog/plm_pkg.sv
// Types of the eight-cell output macrocell array
`include "plm_regs.svh"

package plm_pkg;

    typedef enum logic [1:0] {
        plm_mode_reg,
        plm_mode_cplx,
        plm_mode_simple
    } plm_mode_e;

    typedef enum logic [1:0] {
        plm_cell_reg,
        plm_cell_comb,
        plm_cell_input
    } plm_cell_e;

    // One bit per literal: low half true inputs, high half complements
    typedef logic [`PLM_TERMS-1:0][2*`PLM_LINES-1:0] plm_fuse_t;

    typedef struct packed {
        plm_cell_e                 option;
        logic                      invert;
        logic [`PLM_TERMS-1:0]     term_en;
        plm_fuse_t                 fuse;
    } plm_cell_cfg_s;

    typedef struct packed {
        logic [`PLM_CELLS-1:0]     out;
        logic [`PLM_CELLS-1:0]     oe;
    } plm_pad_s;

    typedef struct packed {
        logic                      pclk;
        logic                      oe_n;
        logic [`PLM_DED_INPUTS-1:0] ded;
        logic [`PLM_CELLS-1:0]     io;
    } plm_sync_s;

endpackage

// >>> verilog/plm_macrocell.sv
// AND-array slice and sum terms of one macrocell
`include "plm_regs.svh"

module plm_macrocell
    import plm_pkg::*;
#(
    parameter int N_LINES = `PLM_LINES,
    parameter int N_TERMS = `PLM_TERMS
)
(
    input  wire logic [N_LINES-1:0]                lines,
    input  wire logic [N_TERMS-1:0]                term_en,
    input  wire logic [N_TERMS-1:0][2*N_LINES-1:0] fuse,
    output logic                                   sum_all,
    output logic                                   sum_rest,
    output logic                                   oe_term
);

    logic [2*N_LINES-1:0] lits;
    logic [N_TERMS-1:0]   terms;

    if (N_TERMS < 2 || N_LINES < 1)
    begin : g_bad_size
        $error("plm_macrocell: needs at least two terms and one line");
    end

    always_comb
    begin
        lits = {~lines, lines};
        for (int t = 0; t < N_TERMS; t++)
        begin
            // Unconnected literal counts as true; disabled term is zero
            terms[t] = term_en[t] & (&(lits | ~fuse[t]));
        end
        sum_all  = |terms;
        sum_rest = |terms[N_TERMS-1:`PLM_OE_TERM+1];
        oe_term  = terms[`PLM_OE_TERM];
    end

endmodule

// >>> verilog/plm_array.sv
// Eight-cell output macrocell array with registered, complex and simple modes
`include "plm_regs.svh"

module plm_array
    import plm_pkg::*;
#(
    parameter int N_CELLS = `PLM_CELLS,
    parameter int N_TERMS = `PLM_TERMS
)
(
    input  wire logic                        clock,
    input  wire logic                        sys_rst,
    input  wire plm_mode_e                   mode,
    input  wire plm_cell_cfg_s [N_CELLS-1:0] cell_cfg,
    input  wire logic                        pin_clk,
    input  wire logic                        pin_oe_n,
    input  wire logic [N_CELLS-1:0]          ded_in,
    input  wire logic [N_CELLS-1:0]          io_in,
    output plm_pad_s                         io_pad,
    output logic [N_CELLS-1:0]               reg_state
);

    if (N_CELLS != `PLM_CELLS || N_TERMS != `PLM_TERMS)
    begin : g_bad_size
        $error("plm_array: routing is fixed to eight cells of eight terms");
    end

    plm_sync_s             meta_r;
    plm_sync_s             meta_nxt;
    plm_sync_s             sync_r;
    plm_sync_s             sync_nxt;
    logic                  pclk_prev_r;
    logic                  pclk_prev_nxt;
    logic                  pclk_rise;

    logic [N_CELLS-1:0]    q_r;
    logic [N_CELLS-1:0]    q_nxt;
    plm_pad_s              pad_r;
    plm_pad_s              pad_nxt;

    logic [N_CELLS-1:0]    fb;
    logic [2*N_CELLS-1:0]  lines;
    logic [N_CELLS-1:0]    sum_all;
    logic [N_CELLS-1:0]    sum_rest;
    logic [N_CELLS-1:0]    oe_term;
    logic [N_CELLS-1:0]    invert;

    logic [N_CELLS-1:0]    reg_mask;
    logic [N_CELLS-1:0]    in_mask;
    logic [N_CELLS-1:0]    pt_oe_mask;
    logic [N_CELLS-1:0]    full_mask;

    // Pin synchroniser and clock pin edge detect
    always_comb
    begin
        meta_nxt.pclk = pin_clk;
        meta_nxt.oe_n = pin_oe_n;
        meta_nxt.ded  = ded_in;
        meta_nxt.io   = io_in;
        sync_nxt      = meta_r;
        pclk_prev_nxt = sync_r.pclk;
        pclk_rise     = sync_r.pclk & ~pclk_prev_r;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            meta_r      <= `PLM_SYNC_RST;
            sync_r      <= `PLM_SYNC_RST;
            pclk_prev_r <= `PLM_PCLK_RST;
        end
        else
        begin
            meta_r      <= meta_nxt;
            sync_r      <= sync_nxt;
            pclk_prev_r <= pclk_prev_nxt;
        end
    end

    // Feedback routing into the AND-array; config is static, not synchronised
    always_comb
    begin
        fb = '0;
        case (mode)
            plm_mode_reg:
            begin
                // Pins 1 and 11 never reach the array here
                for (int i = 0; i < N_CELLS; i++)
                begin
                    fb[i] = (cell_cfg[i].option == plm_cell_reg) ? q_r[i] : sync_r.io[i];
                end
            end
            plm_mode_cplx:
            begin
                fb = sync_r.io;
                fb[`PLM_OUTER_HI] = sync_r.pclk;
                fb[`PLM_OUTER_LO] = sync_r.oe_n;
            end
            plm_mode_simple:
            begin
                // Each pin shifts one position inward; centre pins unused
                fb[0] = sync_r.oe_n;
                fb[1] = sync_r.io[0];
                fb[2] = sync_r.io[1];
                fb[3] = sync_r.io[2];
                fb[4] = sync_r.io[5];
                fb[5] = sync_r.io[6];
                fb[6] = sync_r.io[7];
                fb[7] = sync_r.pclk;
            end
            default:
            begin
                fb = '0;
            end
        endcase
        lines = {fb, sync_r.ded};
    end

    // One AND-array slice per cell
    for (genvar c = 0; c < N_CELLS; c++)
    begin : g_cell
        plm_macrocell #(
            .N_LINES (2*N_CELLS),
            .N_TERMS (N_TERMS)
        ) u_cell (
            .lines    (lines),
            .term_en  (cell_cfg[c].term_en),
            .fuse     (cell_cfg[c].fuse),
            .sum_all  (sum_all[c]),
            .sum_rest (sum_rest[c]),
            .oe_term  (oe_term[c])
        );
        assign invert[c] = cell_cfg[c].invert;
    end

    // Per-cell behaviour by mode and option
    always_comb
    begin
        q_nxt      = q_r;
        pad_nxt    = pad_r;
        reg_mask   = '0;
        in_mask    = '0;
        pt_oe_mask = '0;
        full_mask  = '0;
        for (int i = 0; i < N_CELLS; i++)
        begin
            case (mode)
                plm_mode_reg:
                begin
                    if (cell_cfg[i].option == plm_cell_reg)
                    begin
                        reg_mask[i] = 1'b1;
                        if (pclk_rise)
                        begin
                            q_nxt[i] = sum_all[i];
                        end
                        // Register low drives the pin high
                        pad_nxt.out[i] = ~q_nxt[i];
                        pad_nxt.oe[i]  = ~sync_r.oe_n;
                    end
                    else if (cell_cfg[i].option == plm_cell_input)
                    begin
                        in_mask[i] = 1'b1;
                    end
                    else
                    begin
                        pt_oe_mask[i] = 1'b1;
                        pad_nxt.out[i] = sum_rest[i] ^ invert[i];
                        pad_nxt.oe[i]  = oe_term[i];
                    end
                end
                plm_mode_cplx:
                begin
                    if (cell_cfg[i].option == plm_cell_input)
                    begin
                        in_mask[i] = 1'b1;
                    end
                    else
                    begin
                        pt_oe_mask[i] = 1'b1;
                        pad_nxt.out[i] = sum_rest[i] ^ invert[i];
                        pad_nxt.oe[i]  = oe_term[i];
                    end
                end
                plm_mode_simple:
                begin
                    if (i == `PLM_CENTRE_LO || i == `PLM_CENTRE_HI ||
                        cell_cfg[i].option != plm_cell_input)
                    begin
                        full_mask[i] = 1'b1;
                        pad_nxt.out[i] = sum_all[i] ^ invert[i];
                        pad_nxt.oe[i]  = 1'b1;
                    end
                    else
                    begin
                        in_mask[i] = 1'b1;
                    end
                end
                default:
                begin
                    in_mask[i] = 1'b1;
                end
            endcase
            if (in_mask[i])
            begin
                pad_nxt.out[i] = 1'b0;
                pad_nxt.oe[i]  = 1'b0;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            q_r        <= `PLM_REG_RST;
            pad_r.out  <= `PLM_PIN_RST;
            pad_r.oe   <= `PLM_OE_RST;
        end
        else
        begin
            q_r   <= q_nxt;
            pad_r <= pad_nxt;
        end
    end

    assign io_pad    = pad_r;
    assign reg_state = q_r;

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    sequence s_reg_edge;
        mode == plm_mode_reg && pclk_rise;
    endsequence

    sequence s_pin_rise;
        mode == plm_mode_reg && $rose(sync_r.pclk) && !$past(sync_r.pclk);
    endsequence

    property p_capture;
        s_reg_edge |=> ((q_r ^ $past(sum_all)) & $past(reg_mask)) == '0;
    endproperty

    property p_pin_to_state;
        s_pin_rise ##0 (reg_mask != '0) |=>
            ((reg_state ^ $past(sum_all)) & $past(reg_mask)) == '0 ##0
            ((io_pad.out ^ ~reg_state) & $past(reg_mask)) == '0;
    endproperty

    a_reg_capture: assert property (p_capture)
        else $error("registered cell did not capture its eight-term sum");

    a_reg_pin_path: assert property (p_pin_to_state)
        else $error("registered pin does not show the inverted register");

    a_reg_hold: assert property (!pclk_rise |=> $stable(q_r))
        else $error("register changed without a clock pin edge");

    a_reg_oe_pin: assert property (
        mode == plm_mode_reg |=>
            ((io_pad.oe ^ {N_CELLS{~$past(sync_r.oe_n)}}) & $past(reg_mask)) == '0)
        else $error("registered driver does not follow enable pin");

    a_no_pin_inputs: assert property (
        mode == plm_mode_reg |->
            ((fb ^ sync_r.io) & ~reg_mask) == '0 && ((fb ^ q_r) & reg_mask) == '0)
        else $error("clock or enable pin reached the array");

    a_term_oe: assert property (
        1'b1 |=> ((io_pad.oe ^ $past(oe_term)) & $past(pt_oe_mask)) == '0 ##0
            ((io_pad.out ^ $past(sum_rest) ^ $past(invert)) & $past(pt_oe_mask)) == '0)
        else $error("term-enabled cell output or enable is wrong");

    a_input_off: assert property (1'b1 |=> (io_pad.oe & $past(in_mask)) == '0)
        else $error("input cell drives its pin");

    a_cplx_outer: assert property (
        mode == plm_mode_cplx |->
            fb[`PLM_OUTER_HI] == sync_r.pclk && fb[`PLM_OUTER_LO] == sync_r.oe_n)
        else $error("pins 1 and 11 not on outer feedback paths");

    a_cplx_inner: assert property (
        mode == plm_mode_cplx |-> fb[6:1] == sync_r.io[6:1])
        else $error("inner cell pin level not fed back");

    a_cplx_all_pt: assert property (
        mode == plm_mode_cplx |-> (pt_oe_mask | in_mask) == '1)
        else $error("complex cell without product-term enable");

    a_simple_sum: assert property (
        mode == plm_mode_simple |=>
            ((io_pad.out ^ $past(sum_all) ^ $past(invert)) & $past(full_mask)) == '0)
        else $error("simple cell does not sum eight terms");

    a_simple_fb: assert property (
        mode == plm_mode_simple |->
            fb[3:1] == sync_r.io[2:0] && fb[6:4] == sync_r.io[7:5])
        else $error("simple feedback not via neighbour position");

    a_simple_centre: assert property (
        mode == plm_mode_simple [*2] |-> io_pad.oe[4:3] == 2'b11)
        else $error("centre cells not enabled");

    a_simple_oe: assert property (
        mode == plm_mode_simple |=> io_pad.oe == ~$past(in_mask))
        else $error("simple cell enable does not match option");

    a_reset_low: assert property (
        $fell(sys_rst) |-> io_pad.out == `PLM_PIN_RST && io_pad.oe == `PLM_OE_RST)
        else $error("pins not high after reset");

endmodule

// >>> test/plm_board.sv
// Board model: pull-ups and external drivers on the eight I/O pins
module plm_board
    import plm_pkg::*;
(
    input  wire plm_pad_s   pad,
    input  wire logic [7:0] drv_en,
    input  wire logic [7:0] drv_val,
    output logic [7:0]      io_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Driven pin wins, else board driver, else pull-up
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            io_in[i] = pad.oe[i] ? pad.out[i] : (drv_en[i] ? drv_val[i] : 1'h1);
    end
endmodule

// >>> test/plm_array_bench.sv
// Self-checking bench of the macrocell array in its three modes
module plm_array_bench
    import plm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic                 clock;
    logic                 sys_rst;
    plm_mode_e            mode;
    plm_cell_cfg_s [7:0]  cfg;
    logic                 pin_clk;
    logic                 pin_oe_n;
    logic [7:0]           ded_in;
    logic [7:0]           io_in;
    logic [7:0]           drv_en;
    logic [7:0]           drv_val;
    logic [7:0]           reg_state;
    plm_pad_s             io_pad;
    int                   error_cnt;
    int                   compares;
    int                   cycle_cnt;

    plm_array uut (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .mode      (mode),
        .cell_cfg  (cfg),
        .pin_clk   (pin_clk),
        .pin_oe_n  (pin_oe_n),
        .ded_in    (ded_in),
        .io_in     (io_in),
        .io_pad    (io_pad),
        .reg_state (reg_state)
    );

    plm_board board (
        .pad     (io_pad),
        .drv_en  (drv_en),
        .drv_val (drv_val),
        .io_in   (io_in)
    );

    initial
    begin
        clock = 1'h0;
        forever #2.5 clock = ~clock;
    end

    task automatic end_of_test();
        $display("errors=%0d compares=%0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycle_cnt++;
        if (cycle_cnt == 4000)
        begin
            error_cnt++;
            end_of_test();
        end
    end

    // One cell: term 0 on literal l0, terms 1..7 on literal l1 (negative = none)
    function automatic plm_cell_cfg_s mk(input plm_cell_e opt, input logic inv,
                                         input logic [7:0] en, input int l0, input int l1);
        plm_cell_cfg_s c;
        c = '0;
        c.option = opt;
        c.invert = inv;
        c.term_en = en;
        if (l0 >= 0)
            c.fuse[0][l0] = 1'h1;
        for (int t = 1; t < 8; t++)
            if (l1 >= 0)
                c.fuse[t][l1] = 1'h1;
        return c;
    endfunction

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pad(input logic [7:0] out, input logic [7:0] oe);
        chk(io_pad.out, out);
        chk(io_pad.oe, oe);
    endtask

    // Pin levels applied off the sampling edge, then settle through synchronisers
    task automatic pins(input logic [7:0] d, input logic oen, input logic ck,
                        input logic [7:0] dv);
        @(negedge clock);
        ded_in = d;
        pin_oe_n = oen;
        pin_clk = ck;
        drv_val = dv;
        repeat (10) @(negedge clock);
    endtask

    task automatic do_reset(input plm_mode_e m, input logic [7:0] den);
        @(negedge clock);
        sys_rst = 1'h1;
        mode = m;
        drv_en = den;
        repeat (12) @(negedge clock);
        chk_pad(8'hFF, 8'h00);
        chk(reg_state, 8'h00);
        sys_rst = 1'h0;
    endtask

    initial
    begin
        sys_rst = 1'h1;
        mode = plm_mode_reg;
        cfg = '0;
        pin_clk = 1'h0;
        pin_oe_n = 1'h1;
        ded_in = 8'h00;
        drv_en = 8'h00;
        drv_val = 8'h00;
        error_cnt = 0;
        compares = 0;
        cycle_cnt = 0;
        // Registered mode: cells 0,3 registered, 1 combinatorial, rest inputs
        for (int i = 0; i < 8; i++)
            cfg[i] = mk(plm_cell_input, 1'h0, 8'h00, -1, -1);
        cfg[0] = mk(plm_cell_reg, 1'h0, 8'h01, 0, -1);
        cfg[1] = mk(plm_cell_comb, 1'h0, 8'h03, 1, 2);
        cfg[3] = mk(plm_cell_reg, 1'h0, 8'h80, -1, 16);
        do_reset(plm_mode_reg, 8'h00);
        pins(8'h07, 1'h0, 1'h0, 8'h00);
        chk_pad(8'h0B, 8'h0B);
        pins(8'h05, 1'h0, 1'h1, 8'h00);
        pins(8'h05, 1'h0, 1'h0, 8'h00);
        chk(reg_state, 8'h01);
        chk_pad(8'h0A, 8'h09);
        pins(8'h00, 1'h1, 1'h0, 8'h00);
        chk(reg_state, 8'h01);
        chk_pad(8'h08, 8'h00);
        pins(8'h00, 1'h1, 1'h1, 8'h00);
        chk(reg_state, 8'h08);
        chk_pad(8'h01, 8'h00);
        // Mid-run reset with clock pin held high: no capture may follow
        do_reset(plm_mode_reg, 8'h00);
        pins(8'h00, 1'h1, 1'h1, 8'h00);
        chk(reg_state, 8'h00);
        chk_pad(8'h09, 8'h00);
        // Complex mode: pins 1/11 via outer feedback, inner pins read back
        for (int i = 0; i < 8; i++)
            cfg[i] = mk(plm_cell_input, 1'h0, 8'h00, -1, -1);
        cfg[0] = mk(plm_cell_comb, 1'h0, 8'h03, -1, 8);
        cfg[1] = mk(plm_cell_comb, 1'h0, 8'hFF, -1, 15);
        cfg[2] = mk(plm_cell_comb, 1'h0, 8'h03, -1, 9);
        cfg[4] = mk(plm_cell_comb, 1'h0, 8'h03, -1, 11);
        cfg[7] = mk(plm_cell_comb, 1'h1, 8'h03, 3, 4);
        do_reset(plm_mode_cplx, 8'h08);
        pins(8'h08, 1'h0, 1'h1, 8'h00);
        chk_pad(8'h86, 8'h97);
        pins(8'h00, 1'h1, 1'h0, 8'h08);
        chk_pad(8'h91, 8'h17);
        // Simple mode: neighbour feedback, centre cells forced outputs
        for (int i = 0; i < 8; i++)
            cfg[i] = mk(plm_cell_input, 1'h0, 8'h00, -1, -1);
        cfg[1] = mk(plm_cell_comb, 1'h0, 8'h80, -1, 9);
        cfg[2] = mk(plm_cell_comb, 1'h0, 8'h80, -1, 8);
        cfg[3] = mk(plm_cell_input, 1'h0, 8'h01, 0, -1);
        cfg[4] = mk(plm_cell_input, 1'h1, 8'h80, -1, 16);
        cfg[6] = mk(plm_cell_comb, 1'h0, 8'h80, -1, 12);
        cfg[7] = mk(plm_cell_comb, 1'h0, 8'h80, -1, 15);
        do_reset(plm_mode_simple, 8'h21);
        pins(8'h00, 1'h1, 1'h0, 8'h01);
        chk_pad(8'h06, 8'hDE);
        pins(8'h01, 1'h0, 1'h1, 8'h20);
        chk_pad(8'hD8, 8'hDE);
        end_of_test();
    end
endmodule
